// file: hdl/insn_decoder.sv
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
// Overview of operation
// (RULE_01) Single-word instruction is 24 bits: 8-bit opcode plus operand fields.
// (RULE_02) Exactly three opcodes use two program words; all others use one.
// (RULE_03) Two-word instructions are gathered into 48 bits before issue.
// (RULE_04) Second word of a two-word instruction has its top eight bits zero.
// (RULE_05) A stray second word executes as a no-operation.
// (RULE_06) One cycle normally; two when a test is true or the PC changes.
// (RULE_07) Branch, indirect jump, table access and returns take two or three cycles.
// (RULE_08) A taken skip costs two cycles, three over a two-word instruction.
// (RULE_09) Double-word data moves take two cycles.
// (RULE_10) Two-word instructions take two cycles.
// (RULE_11) Working-register ops decode base source, second source and destination.
// (RULE_12) File-register ops decode an address and a result destination selector.
// (RULE_13) File register address spans 0 to 0x1FFF.
// (RULE_14) Bit select field is four bits, positions 0 to 15.
// (RULE_15) Unsigned ten-bit literal limited to 255 in byte mode, 1023 in word.
// (RULE_16) Program address literal has its least significant bit zero.
// (RULE_17) Signed ten-bit literal is two's complement, -512 to 511.
// (RULE_18) Size suffix selects byte, word or double word; word is default.
// (RULE_19) Five integer flags and four accumulator overflow/saturate flags are kept.
// (RULE_20) Multiply-accumulate decodes accumulator, multiplier pair, prefetches, write-back.
// (RULE_21) Write-back goes to register 13 or its target, post-incremented by two.
// (RULE_22) Other DSP ops take shift from a register or a literal.
// (RULE_23) Issue stalls while the second word is fetched.
module insn_decoder
    import dec_pkg::*;
#(
    parameter int COUNT_W = 16
) (
    input  wire logic            clock,
    input  wire logic            rst_n,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            fetch_valid,
    input  wire logic [23:0]     fetch_word,
    output logic                 fetch_ready,
    input  wire logic            cond_true,
    input  wire logic            skip_two_word,
    input  wire logic            flag_we,
    input  wire dec_pkg::flags_t flag_in,
    output logic                 issue_valid,
    output dec_pkg::dec_t        issue,
    output logic                 nop_cycle,
    output dec_pkg::flags_t      flags
);
    import dec_pkg::*;

    generate
        if (COUNT_W < 8 || COUNT_W > 32) begin : g_bad_width
            $error("COUNT_W must lie between 8 and 32");
        end
    endgenerate

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WORD2 = 2'b01,
        ST_EXEC  = 2'b11
    } state_t;

    typedef struct packed {
        state_t               state;
        logic [23:0]          word1;
        logic [1:0]           cnt;
        logic                 fetch_ready;
        logic                 issue_valid;
        dec_t                 issue;
        logic                 nop_cycle;
        logic                 enable;
        logic                 err_word2;
        logic                 err_addr;
        flags_t               flags;
        logic [COUNT_W-1:0]   icount;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
    } st_t;

    st_t r_r;
    st_t r_nxt;

    function automatic cls_t classify(input logic [7:0] op);
        cls_t c;
        c = CLS_ILLEGAL;
        case (op)
            OP_NOP:         c = CLS_NOP; // RULE_05
            OP_BRANCH:      c = CLS_BRANCH_ALWAYS;
            OP_COND_BRANCH: c = CLS_COND;
            OP_INDIRECT:    c = CLS_INDIRECT;
            OP_TABLE:       c = CLS_TABLE;
            OP_RETURN:      c = CLS_RETURN;
            OP_INT_EXIT:    c = CLS_INTERRUPT_EXIT;
            OP_SKIP:        c = CLS_SKIP;
            OP_ABS_JUMP,
            OP_CALL_LONG,
            OP_LOOP_LONG:   c = CLS_TWO_WORD; // RULE_02
            default: begin
                case (op[7:4])
                    GRP_WORK: c = CLS_WORK;
                    GRP_FILE: c = CLS_FILE;
                    GRP_BIT:  c = CLS_BIT;
                    GRP_LIT:  c = CLS_LITERAL;
                    GRP_MULT: c = CLS_MULTIPLY_ACCUMULATE;
                    GRP_DSP:  c = CLS_DSP;
                    default:  c = CLS_ILLEGAL;
                endcase
            end
        endcase
        return c;
    endfunction : classify

    function automatic dec_t decode(
        input logic [23:0] w1,
        input logic [23:0] w2,
        input logic        cond,
        input logic        skip2
    );
        dec_t        d;
        logic [15:0] f;
        logic [9:0]  l10;
        d = '0;
        f = w1[15:0];
        l10 = f[LIT_LSB +: 10];
        d.opcode = w1[OPC_LSB +: OPC_W]; // RULE_01
        d.cls = classify(d.opcode);
        d.size = SZ_WORD;
        if (d.cls inside {CLS_WORK, CLS_FILE, CLS_LITERAL}) begin
            case (d.opcode[1:0]) // RULE_18
                2'h1:    d.size = SZ_BYTE;
                2'h2:    d.size = SZ_DOUBLE;
                default: d.size = SZ_WORD;
            endcase
        end
        case (d.cls)
            CLS_WORK: begin
                d.base_source_reg = f[BASE_LSB +: 4]; // RULE_11
                d.second_source_reg = f[SRC_LSB +: 4];
                d.src_mode = f[SMODE_LSB +: 2];
                d.dest_reg = f[DST_LSB +: 4];
                d.dst_mode = f[DMODE_LSB +: 2];
            end
            CLS_FILE: begin
                d.file_addr = f[FADDR_LSB +: 13]; // RULE_13
                d.to_default_work_reg = f[FDEST_BIT]; // RULE_12
            end
            CLS_BIT: begin
                d.bit_select_field = f[BITSEL_LSB +: 4]; // RULE_14
                d.second_source_reg = f[SRC_LSB +: 4];
                d.src_mode = f[SMODE_LSB +: 2];
            end
            CLS_LITERAL: begin
                if (d.size == SZ_BYTE) begin
                    d.unsigned_literal_ten = {2'h0, l10[7:0]}; // RULE_15
                end else begin
                    d.unsigned_literal_ten = l10; // RULE_15
                end
                d.signed_literal_ten = {{6{l10[9]}}, l10}; // RULE_17
                d.dest_reg = f[SRC_LSB +: 4];
            end
            CLS_MULTIPLY_ACCUMULATE: begin
                d.acc_b_sel = f[ACC_BIT]; // RULE_20
                d.mul_pair = f[PAIR_LSB +: 3];
                d.x_prefetch = f[XPF_LSB +: 4];
                d.y_prefetch = f[YPF_LSB +: 4];
                d.x_dest = f[XDST_LSB +: 2];
                d.y_dest = f[YDST_LSB +: 2];
                case (d.opcode[1:0])
                    2'h1:    d.acc_writeback_dest = WBK_REG; // RULE_21
                    2'h2:    d.acc_writeback_dest = WBK_MEM; // RULE_21
                    default: d.acc_writeback_dest = WBK_NONE;
                endcase
                if (d.acc_writeback_dest != WBK_NONE) begin
                    d.writeback_reg = WB_REG_NUM; // RULE_21
                end
                if (d.acc_writeback_dest == WBK_MEM) begin
                    d.writeback_inc = WB_POST_INC; // RULE_21
                end
            end
            CLS_DSP: begin
                d.acc_b_sel = f[ACC_BIT];
                d.shift_from_lit = f[SHLIT_BIT]; // RULE_22
                if (f[SHLIT_BIT]) begin
                    d.shift_amount = f[SHAMT_LSB +: 6]; // RULE_22
                end else begin
                    d.second_source_reg = f[SHAMT_LSB +: 4]; // RULE_22
                end
            end
            CLS_TWO_WORD: begin
                d.program_address_literal = {w2[HI_ADDR_W-1:0], f[15:1], 1'b0}; // RULE_03 RULE_16
            end
            default: begin
                d.dest_reg = f[SRC_LSB +: 4];
            end
        endcase
        case (d.cls)
            CLS_TWO_WORD:       d.cycles = CYC_TWO; // RULE_10
            CLS_BRANCH_ALWAYS,
            CLS_INDIRECT,
            CLS_TABLE:          d.cycles = CYC_TWO; // RULE_07
            CLS_RETURN,
            CLS_INTERRUPT_EXIT: d.cycles = CYC_THREE; // RULE_07
            CLS_SKIP:           d.cycles = !cond ? CYC_ONE : (skip2 ? CYC_THREE : CYC_TWO); // RULE_08
            CLS_COND:           d.cycles = cond ? CYC_TWO : CYC_ONE; // RULE_06
            default:            d.cycles = (d.size == SZ_DOUBLE) ? CYC_TWO : CYC_ONE; // RULE_09 RULE_06
        endcase
        return d;
    endfunction : decode

    function automatic logic reg_hit(input logic [7:0] a);
        return a inside {REG_CTRL, REG_STATUS, REG_FLAGS, REG_COUNT, REG_LAST};
    endfunction : reg_hit

    logic        take;
    logic        wr;
    logic        rd;
    logic        do_issue;
    logic [31:0] rdata;
    dec_t        d;

    always_comb begin
        r_nxt = r_r;
        take = r_r.fetch_ready & fetch_valid;
        wr = psel & penable & r_r.pready & pwrite;
        rd = psel & penable & ~r_r.pready;
        do_issue = 1'b0;
        d = '0;
        rdata = 32'h0;

        // Register access: write lands on the edge that sees pready
        case (paddr)
            REG_CTRL:   rdata[CTRL_EN_BIT] = r_r.enable;
            REG_STATUS: begin
                rdata[ST_ERR2_BIT] = r_r.err_word2;
                rdata[ST_ERRA_BIT] = r_r.err_addr;
                rdata[ST_STATE_LSB +: 2] = r_r.state;
            end
            REG_FLAGS:  rdata[8:0] = r_r.flags;
            REG_COUNT:  rdata[COUNT_W-1:0] = r_r.icount;
            REG_LAST:   rdata[23:0] = r_r.word1;
            default:    rdata = 32'h0;
        endcase
        r_nxt.pready = rd;
        r_nxt.pslverr = rd & ~reg_hit(paddr);
        r_nxt.prdata = (rd & ~pwrite) ? rdata : 32'h0;
        if (wr) begin
            case (paddr)
                REG_CTRL:   r_nxt.enable = pwdata[CTRL_EN_BIT];
                REG_STATUS: begin
                    if (pwdata[ST_ERR2_BIT]) begin
                        r_nxt.err_word2 = 1'b0;
                    end
                    if (pwdata[ST_ERRA_BIT]) begin
                        r_nxt.err_addr = 1'b0;
                    end
                end
                REG_FLAGS:  r_nxt.flags = flags_t'(pwdata[8:0]); // RULE_19
                default:    r_nxt.enable = r_r.enable;
            endcase
        end

        // Fetch and issue sequencing
        r_nxt.issue_valid = 1'b0;
        case (r_r.state)
            ST_IDLE: begin
                if (take) begin
                    r_nxt.word1 = fetch_word;
                    if (classify(fetch_word[OPC_LSB +: OPC_W]) == CLS_TWO_WORD) begin
                        r_nxt.state = ST_WORD2; // RULE_23
                    end else begin
                        d = decode(fetch_word, 24'h0, cond_true, skip_two_word);
                        do_issue = 1'b1;
                    end
                end
            end
            ST_WORD2: begin
                if (take) begin
                    if (fetch_word[OPC_LSB +: OPC_W] != 8'h00) begin
                        r_nxt.err_word2 = 1'b1; // RULE_04
                    end
                    if (r_r.word1[0]) begin
                        r_nxt.err_addr = 1'b1; // RULE_16
                    end
                    d = decode(r_r.word1, fetch_word, cond_true, skip_two_word); // RULE_03
                    do_issue = 1'b1;
                end
            end
            ST_EXEC: begin
                if (r_r.cnt <= CYC_ONE) begin
                    r_nxt.state = ST_IDLE;
                end else begin
                    r_nxt.cnt = r_r.cnt - CYC_ONE; // RULE_07
                end
            end
            default: r_nxt.state = ST_IDLE;
        endcase
        if (do_issue) begin
            r_nxt.issue = d;
            r_nxt.issue_valid = 1'b1;
            r_nxt.icount = r_r.icount + COUNT_W'(1);
            if (d.cycles > CYC_ONE) begin
                r_nxt.state = ST_EXEC; // RULE_06
                r_nxt.cnt = d.cycles - CYC_ONE;
            end else begin
                r_nxt.state = ST_IDLE;
            end
        end
        // Extra cycles run as no-operations with fetch held off
        r_nxt.nop_cycle = (r_nxt.state == ST_EXEC); // RULE_06
        r_nxt.fetch_ready = r_nxt.enable & (r_nxt.state != ST_EXEC);
        if (flag_we) begin
            r_nxt.flags = flag_in; // RULE_19
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            r_r <= '0;
            r_r.enable <= CTRL_EN_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign prdata      = r_r.prdata;
    assign pready      = r_r.pready;
    assign pslverr     = r_r.pslverr;
    assign fetch_ready = r_r.fetch_ready;
    assign issue_valid = r_r.issue_valid;
    assign issue       = r_r.issue;
    assign nop_cycle   = r_r.nop_cycle;
    assign flags       = r_r.flags;
endmodule : insn_decoder

// file: hdl/dec_pkg.sv
package dec_pkg;
    // Opcode byte sits in the top of every first word
    localparam int          OPC_LSB        = 16;
    localparam int          OPC_W          = 8;
    localparam logic [7:0]  OP_NOP         = 8'h00;
    localparam logic [7:0]  OP_BRANCH      = 8'h01;
    localparam logic [7:0]  OP_COND_BRANCH = 8'h02;
    localparam logic [7:0]  OP_INDIRECT    = 8'h03;
    localparam logic [7:0]  OP_TABLE       = 8'h04;
    localparam logic [7:0]  OP_RETURN      = 8'h05;
    localparam logic [7:0]  OP_INT_EXIT    = 8'h06;
    localparam logic [7:0]  OP_SKIP        = 8'h07;
    localparam logic [7:0]  OP_ABS_JUMP    = 8'h08;
    localparam logic [7:0]  OP_CALL_LONG   = 8'h09;
    localparam logic [7:0]  OP_LOOP_LONG   = 8'h0A;
    localparam logic [3:0]  GRP_CONTROL    = 4'h0;
    localparam logic [3:0]  GRP_WORK       = 4'h1;
    localparam logic [3:0]  GRP_FILE       = 4'h2;
    localparam logic [3:0]  GRP_BIT        = 4'h3;
    localparam logic [3:0]  GRP_LIT        = 4'h4;
    localparam logic [3:0]  GRP_MULT       = 4'h5;
    localparam logic [3:0]  GRP_DSP        = 4'h6;
    // Operand field positions within the low 16 bits
    localparam int BASE_LSB   = 12;
    localparam int DMODE_LSB  = 10;
    localparam int DST_LSB    = 6;
    localparam int SMODE_LSB  = 4;
    localparam int SRC_LSB    = 0;
    localparam int FADDR_LSB  = 0;
    localparam int FDEST_BIT  = 13;
    localparam int BITSEL_LSB = 12;
    localparam int LIT_LSB    = 4;
    localparam int ACC_BIT    = 15;
    localparam int PAIR_LSB   = 12;
    localparam int XPF_LSB    = 8;
    localparam int YPF_LSB    = 4;
    localparam int XDST_LSB   = 2;
    localparam int YDST_LSB   = 0;
    localparam int SHLIT_BIT  = 14;
    localparam int SHAMT_LSB  = 0;
    localparam int HI_ADDR_W  = 7;
    localparam logic [3:0] WB_REG_NUM   = 4'hD;
    localparam logic [1:0] WB_POST_INC  = 2'h2;
    localparam logic [1:0] CYC_ONE   = 2'h1;
    localparam logic [1:0] CYC_TWO   = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    // Register map, byte addresses
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FLAGS  = 8'h08;
    localparam logic [7:0] REG_COUNT  = 8'h0C;
    localparam logic [7:0] REG_LAST   = 8'h10;
    localparam int   CTRL_EN_BIT  = 0;
    localparam logic CTRL_EN_RST  = 1'b1;
    localparam int   ST_ERR2_BIT  = 0;
    localparam int   ST_ERRA_BIT  = 1;
    localparam int   ST_STATE_LSB = 2;

    typedef enum logic [3:0] {
        CLS_NOP, CLS_WORK, CLS_FILE, CLS_BIT, CLS_LITERAL,
        CLS_MULTIPLY_ACCUMULATE, CLS_DSP, CLS_BRANCH_ALWAYS, CLS_COND,
        CLS_INDIRECT, CLS_TABLE, CLS_RETURN, CLS_INTERRUPT_EXIT,
        CLS_SKIP, CLS_TWO_WORD, CLS_ILLEGAL
    } cls_t;
    typedef enum logic [1:0] {SZ_WORD, SZ_BYTE, SZ_DOUBLE} size_t;
    typedef enum logic [1:0] {WBK_NONE, WBK_REG, WBK_MEM} wbk_t;

    typedef struct packed {
        logic       carry_flag;
        logic       half_carry_flag;
        logic       negative_flag;
        logic       signed_overflow_flag;
        logic       zero_flag;
        logic       acc_a_overflow_flag;
        logic       acc_b_overflow_flag;
        logic       acc_a_saturate_flag;
        logic       acc_b_saturate_flag;
    } flags_t;

    typedef struct packed {
        logic [7:0]  opcode;
        cls_t        cls;
        size_t       size;
        logic [3:0]  base_source_reg;
        logic [3:0]  second_source_reg;
        logic [1:0]  src_mode;
        logic [3:0]  dest_reg;
        logic [1:0]  dst_mode;
        logic [12:0] file_addr;
        logic        to_default_work_reg;
        logic [3:0]  bit_select_field;
        logic [9:0]  unsigned_literal_ten;
        logic [15:0] signed_literal_ten;
        logic [22:0] program_address_literal;
        logic        acc_b_sel;
        logic [2:0]  mul_pair;
        logic [3:0]  x_prefetch;
        logic [3:0]  y_prefetch;
        logic [1:0]  x_dest;
        logic [1:0]  y_dest;
        wbk_t        acc_writeback_dest;
        logic [3:0]  writeback_reg;
        logic [1:0]  writeback_inc;
        logic        shift_from_lit;
        logic [5:0]  shift_amount;
        logic [1:0]  cycles;
    } dec_t;
endpackage : dec_pkg

// file: test/insn_decoder_monitor.sv
`timescale 1ns/10ps
module insn_decoder_monitor
    import dec_pkg::*;
(
    input wire logic            clock,
    input wire logic            rst_n,
    input wire logic            fetch_valid,
    input wire logic [23:0]     fetch_word,
    input wire logic            fetch_ready,
    input wire logic            cond_true,
    input wire logic            skip_two_word,
    input wire logic            flag_we,
    input wire dec_pkg::flags_t flag_in,
    input wire logic            issue_valid,
    input wire dec_pkg::dec_t   issue,
    input wire logic            nop_cycle,
    input wire dec_pkg::flags_t flags
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic take = fetch_valid && fetch_ready;

    one_cycle_a:
        assert property (issue_valid && issue.cycles == CYC_ONE |-> !nop_cycle) else $error("stray extra cycle");
    two_cycle_a:
        assert property (issue_valid && issue.cycles == CYC_TWO |-> nop_cycle ##1 !nop_cycle)
        else $error("two-cycle length");
    three_cycle_a:
        assert property (issue_valid && issue.cycles == CYC_THREE |-> nop_cycle [*2] ##1 !nop_cycle)
        else $error("three-cycle length");
    extra_stall_a:
        assert property (nop_cycle |-> !fetch_ready) else $error("fetch during extra cycle");
    two_word_a:
        assert property (issue_valid && issue.cls == CLS_TWO_WORD |-> issue.cycles == CYC_TWO && $past(take))
        else $error("two-word timing");
    addr_lsb_a:
        assert property (issue_valid && issue.cls == CLS_TWO_WORD |-> !issue.program_address_literal[0])
        else $error("address literal odd");
    cond_cycles_a:
        assert property (take && fetch_word[23:16] == OP_COND_BRANCH
            |=> issue_valid && issue.cycles == ($past(cond_true) ? CYC_TWO : CYC_ONE))
        else $error("cond branch cycles");
    skip_cycles_a:
        assert property (take && fetch_word[23:16] == OP_SKIP && cond_true
            |=> issue_valid && issue.cycles == ($past(skip_two_word) ? CYC_THREE : CYC_TWO))
        else $error("skip cycles");
    flag_load_a:
        assert property (flag_we |=> flags == $past(flag_in)) else $error("flags not loaded");
endmodule : insn_decoder_monitor

bind insn_decoder insn_decoder_monitor mon (.*);

// file: test/fetch_model.sv
`timescale 1ns/10ps
module fetch_model (
    input  wire logic   clock,
    input  wire logic   fetch_ready,
    output logic        fetch_valid,
    output logic [23:0] fetch_word,
    output logic        cond_true,
    output logic        skip_two_word
);
    initial begin
        fetch_valid = 1'h0;
        fetch_word = 24'h0;
        cond_true = 1'h0;
        skip_two_word = 1'h0;
    end

    // Call right after a rising edge
    task automatic offer(input logic [23:0] w, input logic c, input logic s, output logic ok);
        int n;
        n = 0;
        fetch_valid   <= 1'h1;
        fetch_word    <= w;
        cond_true     <= c;
        skip_two_word <= s;
        do begin
            @(posedge clock);
            n++;
        end while (fetch_ready !== 1'h1 && n < 60);
        ok = (fetch_ready === 1'h1);
    endtask : offer

    // Released lines show the inverse
    task automatic idle();
        fetch_valid   <= 1'h0;
        fetch_word    <= ~fetch_word;
        cond_true     <= ~cond_true;
        skip_two_word <= ~skip_two_word;
        @(posedge clock);
    endtask : idle
endmodule : fetch_model

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
    import dec_pkg::*;
    logic        clock   = 1'h0;
    logic        rst_n   = 1'h0;
    logic        psel    = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite  = 1'h0;
    logic [7:0]  paddr   = 8'h0;
    logic [31:0] pwdata  = 32'h0;
    logic        flag_we = 1'h0;
    flags_t      flag_in = '0;
    logic [31:0] prdata, seed, q, last_w;
    logic        pready, pslverr, fetch_valid, fetch_ready, cond_true, skip_two_word, issue_valid, nop_cycle, e;
    logic [23:0] fetch_word;
    dec_t        issue;
    flags_t      flags;
    logic [63:0] e_v, exp_q[$];
    int          err_total = 0;
    int          tests_run = 0;
    int          n_iss = 0;

    always #12.5 clock = ~clock;

    insn_decoder dut (.*);
    fetch_model pm (.*);

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic er);
        int n;
        n = 0;
        @(posedge clock);
        psel   <= 1'h1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1 && n < 20);
        r = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) begin
            err_total++;
            summarize();
        end
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] want, input string what);
        logic [31:0] r;
        logic        er;
        apb(1'h0, a, 32'h0, r, er);
        chk(what, r, want);
    endtask : rd_chk

    // Expected {fields, class, cycles}
    function automatic logic [63:0] model(int w, int w2, logic c, logic s);
        cls_t ctl[8] = '{CLS_NOP, CLS_BRANCH_ALWAYS, CLS_COND, CLS_INDIRECT, CLS_TABLE, CLS_RETURN,
                         CLS_INTERRUPT_EXIT, CLS_SKIP};
        cls_t grp[7] = '{CLS_NOP, CLS_WORK, CLS_FILE, CLS_BIT, CLS_LITERAL, CLS_MULTIPLY_ACCUMULATE, CLS_DSP};
        int   cyc[8] = '{1, 2, 1, 2, 2, 3, 3, 1};
        int   op, g, sz, lit, key, n;
        cls_t k;
        op = (w >> 16) & 255;
        g = op >> 4;
        sz = op & 3;
        key = 0;
        if (op >= 8 && op <= 10) begin
            k = CLS_TWO_WORD;
            n = 2;
            key = ((w2 & 127) << 16) | (w & 32'hFFFE);
        end else if (g == 0) begin
            k = ctl[op];
            n = cyc[op];
            if (c && op == 2)
                n = 2;
            if (c && op == 7)
                n = s ? 3 : 2;
        end else begin
            k = grp[g];
            n = (sz == 2 && g != 3 && g < 5) ? 2 : 1;
            lit = (w >> 4) & 1023;
            case (g)
                1: key = ((w >> 12 & 15) << 8) | ((w >> 6 & 15) << 4) | (w & 15);
                2: key = w & 32'h3FFF;
                3: key = w >> 12 & 15;
                4: key = (((lit >= 512 ? lit - 1024 : lit) & 32'hFFFF) << 10) | (sz == 1 ? lit & 255 : lit);
                5: key = ((sz % 3) << 16) | (w & 32'hFFFF) | (sz % 3 ? 13 << 20 : 0) | (sz == 2 ? 2 << 18 : 0);
                default: key = (w >> 14 & 3) << 6 | ((w >> 14 & 1) ? w & 63 : 0);
            endcase
            if (g != 3 && g < 5)
                key = key | ((sz % 3) << 28);
        end
        return {32'(key), 26'h0, k, 2'(n)};
    endfunction : model

    function automatic logic [31:0] seen_key(dec_t d);
        logic [31:0] k;
        k = 32'h0;
        case (d.cls)
            CLS_WORK: k[11:0] = {d.base_source_reg, d.dest_reg, d.second_source_reg};
            CLS_FILE: k[13:0] = {d.to_default_work_reg, d.file_addr};
            CLS_BIT: k[3:0] = d.bit_select_field;
            CLS_LITERAL: k[25:0] = {d.signed_literal_ten, d.unsigned_literal_ten};
            CLS_MULTIPLY_ACCUMULATE: k[23:0] = {d.writeback_reg, d.writeback_inc, d.acc_writeback_dest, d.acc_b_sel,
                                                d.mul_pair, d.x_prefetch, d.y_prefetch, d.x_dest, d.y_dest};
            CLS_DSP: k[7:0] = {d.acc_b_sel, d.shift_from_lit, d.shift_from_lit ? d.shift_amount : 6'h0};
            CLS_TWO_WORD: k[22:0] = d.program_address_literal;
            default: k = 32'h0;
        endcase
        if (d.cls inside {CLS_WORK, CLS_FILE, CLS_LITERAL})
            k[29:28] = d.size;
        return k;
    endfunction : seen_key

    task automatic ins(input logic [23:0] w1, input logic [23:0] w2, input logic c, input logic s);
        logic ok;
        exp_q.push_back(model(w1, w2, c, s));
        n_iss++;
        last_w = {8'h0, w1};
        pm.offer(w1, c, s, ok);
        if (ok && w1[23:16] inside {OP_ABS_JUMP, OP_CALL_LONG, OP_LOOP_LONG})
            pm.offer(w2, 1'h0, 1'h0, ok);
        if (!ok) begin
            err_total++;
            summarize();
        end
    endtask : ins

    always @(posedge clock) begin
        if (issue_valid === 1'h1) begin
            e_v = exp_q.size() > 0 ? exp_q.pop_front() : '1;
            chk("class and cycles", {26'h0, issue.cls, issue.cycles}, e_v[31:0]);
            chk("operand fields", seen_key(issue), e_v[63:32]);
        end
    end

    initial begin
        seed = 32'h31656CEF;
        repeat (12) @(posedge clock);
        rst_n <= 1'h1;
        rd_chk(REG_CTRL, 32'h1, "control reset");
        rd_chk(REG_STATUS, 32'h0, "status reset");
        rd_chk(REG_FLAGS, 32'h0, "flags reset");
        apb(1'h0, 8'h14, 32'h0, q, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        chk("unmapped data", q, 32'h0);
        for (int i = 0; i < 32; i++)
            ins({5'h0, i[2:0], 16'(rnd())}, 24'h0, i[3], i[4]);
        for (int i = 0; i < 48; i++)
            ins({4'(1 + rnd() % 6), 4'(rnd()), 16'(rnd())}, 24'h0, 1'h0, 1'h0);
        ins(24'h403FF0, 24'h0, 1'h0, 1'h0);
        ins(24'h413FF0, 24'h0, 1'h0, 1'h0);
        for (int i = 8; i < 11; i++)
            ins({8'(i), 16'(rnd()) & 16'hFFFE}, {17'h0, 7'(rnd())}, 1'h0, 1'h0);
        ins(24'h081235, 24'h55007F, 1'h0, 1'h0);
        pm.idle();
        rd_chk(REG_STATUS, 32'h3, "status errors");
        apb(1'h1, REG_STATUS, 32'h3, q, e);
        rd_chk(REG_STATUS, 32'h0, "status cleared");
        flag_in <= flags_t'(9'(rnd()));
        flag_we <= 1'h1;
        @(posedge clock);
        flag_we <= 1'h0;
        rd_chk(REG_FLAGS, {23'h0, flag_in}, "flags load");
        apb(1'h1, REG_FLAGS, 32'h1A5, q, e);
        rd_chk(REG_FLAGS, 32'h1A5, "flags write");
        apb(1'h1, REG_CTRL, 32'h0, q, e);
        repeat (2) @(posedge clock);
        chk("fetch held", {31'h0, fetch_ready}, 32'h0);
        apb(1'h1, REG_CTRL, 32'h1, q, e);
        rd_chk(REG_COUNT, 32'(n_iss), "issue count");
        rd_chk(REG_LAST, last_w, "last word");
        chk("pending issues", 32'(exp_q.size()), 32'h0);
        summarize();
    end
endmodule : testbench
